/* File: src/umsch_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the scheduler
// Assumes: Times are held in microseconds, counts in oscillator ticks
// Notes: Included by the scheduler top module and the testbench
`ifndef UMSCH_MAP_SVH
`define UMSCH_MAP_SVH

// Register byte addresses
`define UMS_ADR_SETUP 4'h0
`define UMS_ADR_STATUS 4'h4

// Setup word fields and reset value
`define UMS_SETUP_RST 16'h0001
`define UMS_B_EN 0
`define UMS_F_RATE 2:1
`define UMS_F_CRES 4:3
`define UMS_F_TRES 6:5
`define UMS_F_MULT 8:7
`define UMS_B_CDENS 9
`define UMS_B_TDENS 10
`define UMS_B_ALARM 11

// Status word fields
`define UMS_F_ST_PHASE 2:0
`define UMS_F_ST_TCNT 5:3
`define UMS_F_ST_CAPS 31:16

// Clock rates
`define UMS_CLK_KHZ 50000
`define UMS_OSC_KHZ 1850

// Times in microseconds
`define UMS_T_WAKE_US 100
`define UMS_T_CDSP_US 300
`define UMS_T_TDSP_US 250
`define UMS_T_CONV8_US 300
`define UMS_T_CONV10_US 1150
`define UMS_T_CONV12_US 4500
`define UMS_T_CONV14_US 18000
`define UMS_T_PD1_US 5000
`define UMS_T_PD2_US 25000
`define UMS_T_PD3_US 125000

// Microseconds to oscillator ticks, rounded up
`define UMS_TICKS(us) ((((us) * `UMS_OSC_KHZ) + 999) / 1000)

// Timing counts in oscillator ticks
`define UMS_N_WAKE `UMS_TICKS(`UMS_T_WAKE_US)
`define UMS_N_CDSP `UMS_TICKS(`UMS_T_CDSP_US)
`define UMS_N_TDSP `UMS_TICKS(`UMS_T_TDSP_US)
`define UMS_N_CONV8 `UMS_TICKS(`UMS_T_CONV8_US)
`define UMS_N_CONV10 `UMS_TICKS(`UMS_T_CONV10_US)
`define UMS_N_CONV12 `UMS_TICKS(`UMS_T_CONV12_US)
`define UMS_N_CONV14 `UMS_TICKS(`UMS_T_CONV14_US)
`define UMS_N_PD1 `UMS_TICKS(`UMS_T_PD1_US)
`define UMS_N_PD2 `UMS_TICKS(`UMS_T_PD2_US)
`define UMS_N_PD3 `UMS_TICKS(`UMS_T_PD3_US)

// Last count of the capacitance cycle counter; six cycles per temperature conversion
`define UMS_TEMP_PERIOD 3'd5

`endif

/* File: src/umsch_pkg.sv */
// Purpose: Types shared by the update mode scheduler
// Assumes: Constants come from umsch_map.svh
// Notes: State of the top module is one packed struct
package umsch_pkg;

  // Scheduler phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_WAKE, PH_TCONV, PH_TDSP, PH_CCONV, PH_CDSP, PH_REFRESH, PH_PDOWN
  } umsch_phase_t;

  // Refresh strobes toward the output stage
  typedef struct packed {
    logic out_reg;
    logic cap_dens;
    logic temp_dens;
    logic alarm;
  } umsch_refresh_t;

  // Activity levels toward the front end
  typedef struct packed {
    logic awake;
    logic temp_busy;
    logic cap_busy;
    logic pwr_down;
  } umsch_activity_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } umsch_wb_req_t;

  // Whole module state
  typedef struct packed {
    umsch_phase_t st;
    logic [15:0] acc;
    logic [17:0] cnt;
    logic [2:0] rep;
    logic [2:0] tcnt;
    logic [15:0] setup;
    logic [15:0] caps;
    logic ack;
    logic [31:0] rdat;
    umsch_refresh_t refr;
  } umsch_state_t;

endpackage : umsch_pkg

/* File: src/umsch_top.sv */
// Purpose: Free running measurement scheduler with Wishbone setup and status
// Assumes: CLK at 50 MHz, NRST synchronous active low, CE freezes all state
// Notes: Oscillator time base is a phase accumulator ticking at 1.85 MHz
// Operation
// - Rate code picks 0/5/25/125 ms power-down
// - Refresh outputs, then enter power-down
// - Timer expiry wakes next cycle unprompted
// - Fastest rate skips power-down entirely
// - Works with every output mode
// - Temperature once per six capacitance cycles
// - Capacitance conversion directly follows temperature
// - Cap spacing: conversion, overheads, power-down
// - Temp spacing: six cap spacings plus temp
// - Multiplier scales capacitance conversion only
// - Resolution code sets conversion length
// - Wake, optional temperature, then capacitance
// - Setup bit enables update mode scheduling
// - All timing from 1.85 MHz oscillator
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "umsch_map.svh"

module umsch_top import umsch_pkg::*; #(
  parameter int WAKE_TICKS = `UMS_N_WAKE,
  parameter int CDSP_TICKS = `UMS_N_CDSP,
  parameter int TDSP_TICKS = `UMS_N_TDSP,
  parameter int CONV8_TICKS = `UMS_N_CONV8,
  parameter int CONV10_TICKS = `UMS_N_CONV10,
  parameter int CONV12_TICKS = `UMS_N_CONV12,
  parameter int CONV14_TICKS = `UMS_N_CONV14,
  parameter int PD1_TICKS = `UMS_N_PD1,
  parameter int PD2_TICKS = `UMS_N_PD2,
  parameter int PD3_TICKS = `UMS_N_PD3
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire umsch_wb_req_t WB_REQ,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output umsch_refresh_t REFRESH,
  output umsch_activity_t ACTIVITY
);

  // Reset image of the state
  localparam umsch_state_t S_RST = '{
    st: PH_IDLE, acc: 16'h0000, cnt: 18'h00000, rep: 3'h0, tcnt: 3'h0,
    setup: `UMS_SETUP_RST, caps: 16'h0000, ack: 1'b0, rdat: 32'h00000000,
    refr: 4'h0};

  umsch_state_t s_ff; // Registered state
  umsch_state_t nxt_s; // Next state
  logic [16:0] osc_sum; // Accumulator plus increment
  logic osc_tick; // One oscillator period elapsed
  logic timer_done; // Phase counter expired on a tick
  logic en; // Update mode selected
  logic wb_req; // New Wishbone access
  logic [1:0] rate; // Power-down rate code
  logic [1:0] mult; // Capacitance multiplier code

  // Conversion length minus one for a resolution code
  function automatic logic [17:0] conv_load(input logic [1:0] res);
    case (res)
      2'h0: conv_load = 18'(CONV8_TICKS - 1);
      2'h1: conv_load = 18'(CONV10_TICKS - 1);
      2'h2: conv_load = 18'(CONV12_TICKS - 1);
      default: conv_load = 18'(CONV14_TICKS - 1);
    endcase
  endfunction : conv_load

  // Power-down length minus one for a nonzero rate code
  function automatic logic [17:0] pd_load(input logic [1:0] r);
    case (r)
      2'h1: pd_load = 18'(PD1_TICKS - 1);
      2'h2: pd_load = 18'(PD2_TICKS - 1);
      default: pd_load = 18'(PD3_TICKS - 1);
    endcase
  endfunction : pd_load

  // Extra conversion repeats for the multiplier code
  function automatic logic [2:0] mult_reps(input logic [1:0] m);
    case (m)
      2'h0: mult_reps = 3'h0;
      2'h1: mult_reps = 3'h1;
      2'h2: mult_reps = 3'h3;
      default: mult_reps = 3'h7;
    endcase
  endfunction : mult_reps

  // Oscillator time base and field decode
  assign osc_sum = {1'b0, s_ff.acc} + 17'(`UMS_OSC_KHZ);
  assign osc_tick = (osc_sum >= 17'(`UMS_CLK_KHZ));
  assign timer_done = osc_tick && (s_ff.cnt == 18'h00000);
  assign en = s_ff.setup[`UMS_B_EN];
  assign rate = s_ff.setup[`UMS_F_RATE];
  assign mult = s_ff.setup[`UMS_F_MULT];
  assign wb_req = WB_REQ.cyc && WB_REQ.stb && !s_ff.ack;

  // Next state: time base, phase sequencer, register file
  always_comb begin
    nxt_s = s_ff;
    nxt_s.refr = 4'h0;
    nxt_s.ack = wb_req;
    // Accumulator wraps once per oscillator period
    if (osc_tick) begin
      nxt_s.acc = 16'(osc_sum - 17'(`UMS_CLK_KHZ));
    end else begin
      nxt_s.acc = osc_sum[15:0];
    end
    // Phase counter runs down on oscillator ticks
    if (osc_tick && s_ff.cnt != 18'h00000) begin
      nxt_s.cnt = s_ff.cnt - 18'h00001;
    end
    case (s_ff.st)
      PH_IDLE: begin
        // Wait for update mode
        if (en) begin
          nxt_s.st = PH_WAKE;
          nxt_s.cnt = 18'(WAKE_TICKS - 1);
          nxt_s.tcnt = 3'h0;
        end
      end
      PH_WAKE: begin
        // Short wake-up, then temperature when due
        if (timer_done) begin
          if (s_ff.tcnt == 3'h0) begin
            nxt_s.st = PH_TCONV;
            nxt_s.cnt = conv_load(s_ff.setup[`UMS_F_TRES]);
          end else begin
            nxt_s.st = PH_CCONV;
            nxt_s.cnt = conv_load(s_ff.setup[`UMS_F_CRES]);
            nxt_s.rep = mult_reps(mult);
          end
        end
      end
      PH_TCONV: begin
        // Temperature conversion, no multiplier
        if (timer_done) begin
          nxt_s.st = PH_TDSP;
          nxt_s.cnt = 18'(TDSP_TICKS - 1);
        end
      end
      PH_TDSP: begin
        // Temperature correction, then capacitance at once
        if (timer_done) begin
          nxt_s.st = PH_CCONV;
          nxt_s.cnt = conv_load(s_ff.setup[`UMS_F_CRES]);
          nxt_s.rep = mult_reps(mult);
        end
      end
      PH_CCONV: begin
        // Base conversion repeated multiplier times
        if (timer_done) begin
          if (s_ff.rep != 3'h0) begin
            nxt_s.rep = s_ff.rep - 3'h1;
            nxt_s.cnt = conv_load(s_ff.setup[`UMS_F_CRES]);
          end else begin
            nxt_s.st = PH_CDSP;
            nxt_s.cnt = 18'(CDSP_TICKS - 1);
          end
        end
      end
      PH_CDSP: begin
        // Capacitance correction, count the cycle
        if (timer_done) begin
          nxt_s.st = PH_REFRESH;
          nxt_s.caps = s_ff.caps + 16'h0001;
          if (s_ff.tcnt == `UMS_TEMP_PERIOD) begin
            nxt_s.tcnt = 3'h0;
          end else begin
            nxt_s.tcnt = s_ff.tcnt + 3'h1;
          end
        end
      end
      PH_REFRESH: begin
        // Refresh every configured output, then sleep unless the rate code is zero
        nxt_s.refr.out_reg = 1'b1;
        nxt_s.refr.cap_dens = s_ff.setup[`UMS_B_CDENS];
        nxt_s.refr.temp_dens = s_ff.setup[`UMS_B_TDENS];
        nxt_s.refr.alarm = s_ff.setup[`UMS_B_ALARM];
        if (!en) begin
          nxt_s.st = PH_IDLE;
        end else if (rate == 2'h0) begin
          nxt_s.st = PH_WAKE;
          nxt_s.cnt = 18'(WAKE_TICKS - 1);
        end else begin
          nxt_s.st = PH_PDOWN;
          nxt_s.cnt = pd_load(rate);
        end
      end
      PH_PDOWN: begin
        // Power-down until timer expiry
        if (!en) begin
          nxt_s.st = PH_IDLE;
        end else if (timer_done) begin
          nxt_s.st = PH_WAKE;
          nxt_s.cnt = 18'(WAKE_TICKS - 1);
        end
      end
      default: begin
        nxt_s.st = PH_IDLE;
      end
    endcase
    // Setup write with byte lanes; other addresses ignore writes
    if (wb_req && WB_REQ.we && WB_REQ.adr == `UMS_ADR_SETUP) begin
      if (WB_REQ.sel[0]) begin
        nxt_s.setup[7:0] = WB_REQ.dat[7:0];
      end
      if (WB_REQ.sel[1]) begin
        nxt_s.setup[15:8] = WB_REQ.dat[15:8];
      end
    end
    // Read data; unmapped reads return zero
    if (wb_req) begin
      nxt_s.rdat = 32'h00000000;
      if (WB_REQ.adr == `UMS_ADR_SETUP) begin
        nxt_s.rdat[15:0] = s_ff.setup;
      end else if (WB_REQ.adr == `UMS_ADR_STATUS) begin
        nxt_s.rdat[`UMS_F_ST_PHASE] = s_ff.st;
        nxt_s.rdat[`UMS_F_ST_TCNT] = s_ff.tcnt;
        nxt_s.rdat[`UMS_F_ST_CAPS] = s_ff.caps;
      end
    end
  end

  // State register, frozen while CE is low
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_ff <= S_RST;
    end else if (CE) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign WB_DAT_O = s_ff.rdat;
  assign WB_ACK_O = s_ff.ack;
  assign REFRESH = s_ff.refr;
  assign ACTIVITY.awake = (s_ff.st != PH_IDLE) && (s_ff.st != PH_PDOWN);
  assign ACTIVITY.temp_busy = (s_ff.st == PH_TCONV) || (s_ff.st == PH_TDSP);
  assign ACTIVITY.cap_busy = (s_ff.st == PH_CCONV) || (s_ff.st == PH_CDSP);
  assign ACTIVITY.pwr_down = (s_ff.st == PH_PDOWN);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Power-down counter loaded from rate code
  chk_pd_load: assert property (s_ff.st == PH_REFRESH && CE && en && rate != 2'h0
    |=> s_ff.st == PH_PDOWN && s_ff.cnt == pd_load($past(rate)))
    else $error("power-down load wrong");

  // Fastest rate goes straight to wake
  chk_fast_rate: assert property (s_ff.st == PH_REFRESH && CE && en && rate == 2'h0
    |=> s_ff.st == PH_WAKE && s_ff.cnt == 18'(WAKE_TICKS - 1))
    else $error("fastest rate entered power-down");

  // Power-down entered only through a refresh that raised the strobe
  chk_refresh_first: assert property ($rose(s_ff.st == PH_PDOWN)
    |-> $past(s_ff.st) == PH_REFRESH && REFRESH.out_reg)
    else $error("power-down without refresh");

  // Timer expiry wakes the part
  chk_wake_expiry: assert property (s_ff.st == PH_PDOWN && timer_done && CE && en
    |=> s_ff.st == PH_WAKE)
    else $error("no wake after power-down");

  // Temperature only when the six-cycle counter is zero
  chk_temp_due: assert property ($rose(s_ff.st == PH_TCONV) |-> s_ff.tcnt == 3'h0
    && $past(s_ff.st) == PH_WAKE)
    else $error("temperature conversion not due");

  // Capacitance right after temperature correction
  chk_cap_follows: assert property (s_ff.st == PH_TDSP && timer_done && CE
    |=> s_ff.st == PH_CCONV && s_ff.rep == mult_reps($past(mult)))
    else $error("capacitance did not follow temperature");

  // Update mode entry starts with temperature due
  chk_entry_temp: assert property (s_ff.st == PH_IDLE && en && CE
    |=> s_ff.st == PH_WAKE && s_ff.tcnt == 3'h0)
    else $error("entry cycle not temperature");

  // Idle holds while update mode is off
  chk_idle_hold: assert property (s_ff.st == PH_IDLE && !en |=> s_ff.st == PH_IDLE)
    else $error("left idle without update mode");

  // Oscillator ticks spaced at least nine clocks apart
  chk_osc_space: assert property (osc_tick && CE |=> !osc_tick [*8])
    else $error("oscillator tick too fast");

  // Counter wraps the six-cycle period
  chk_tcnt_wrap: assert property (s_ff.st == PH_CDSP && timer_done && CE
    && s_ff.tcnt == `UMS_TEMP_PERIOD |=> s_ff.tcnt == 3'h0)
    else $error("temperature counter did not wrap");

endmodule : umsch_top

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the update mode scheduler
// Assumes: Small tick counts, one tick every 50000/1850 clocks
// Notes: Cycle spacing is judged within two clocks of the tick count
`timescale 1ns/1ps
`include "umsch_map.svh"
module testbench import umsch_pkg::*;;
  localparam int WK = 2; // Wake ticks
  localparam int CD = 3; // Cap correction ticks
  localparam int TD = 2; // Temp correction ticks
  localparam int CV [4] = '{2, 3, 4, 5}; // Conversion ticks per code
  localparam int PD [4] = '{0, 3, 4, 6}; // Power-down ticks per code
  logic CLK; // Bench clock
  logic NRST; // Reset, active low
  umsch_wb_req_t req; // Bus request
  logic [31:0] dat_o; // Read data
  logic ack_o; // Bus ack
  umsch_refresh_t refr; // Refresh strobes
  umsch_activity_t act; // Activity levels
  int pulses; // Refresh count
  int gap; // Clocks between refreshes
  logic temp; // Cycle held temperature
  logic pdown; // Cycle held power-down
  umsch_refresh_t last; // Last strobe set
  int miscompares; // Mismatch count
  int total_checks; // Comparison count
  int cycles; // Timeout counter
  logic ce; // Clock enable
  logic [3:0] wsel; // Byte lanes of writes
  umsch_top #(.WAKE_TICKS(WK), .CDSP_TICKS(CD), .TDSP_TICKS(TD), .CONV8_TICKS(CV[0]),
    .CONV10_TICKS(CV[1]), .CONV12_TICKS(CV[2]), .CONV14_TICKS(CV[3]),
    .PD1_TICKS(PD[1]), .PD2_TICKS(PD[2]), .PD3_TICKS(PD[3])) umsch_top_inst (
    .CLK(CLK), .NRST(NRST), .CE(ce), .WB_REQ(req), .WB_DAT_O(dat_o), .WB_ACK_O(ack_o),
    .REFRESH(refr), .ACTIVITY(act));
  umsch_out_model umsch_out_model_inst (.clk(CLK), .nrst(NRST), .refresh(refr),
    .activity(act), .pulses_ff(pulses), .gap_ff(gap), .temp_ff(temp), .pdown_ff(pdown),
    .last_ff(last));
  // Clock generator
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // Hang guard
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      miscompares++;
      test_done();
    end
  end
  // Exact value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Spacing compare, two clocks of slack for tick jitter
  task automatic chk_near(input string nm, input int e, input int g);
    total_checks++;
    if (g > e + 2 || g < e - 2) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_near
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: wsel, dat: d};
    @(posedge CLK);
    while (ack_o !== 1'b1) @(posedge CLK);
    r = dat_o;
    req <= '0;
    @(posedge CLK);
  endtask : wb
  // Wait for the next output refresh
  task automatic wait_pulse();
    int n;
    n = pulses;
    while (pulses == n) @(posedge CLK);
  endtask : wait_pulse
  // Expected clocks of one cycle
  function automatic int exp_clk(input logic [15:0] s, input logic t);
    int k;
    k = WK + CV[s[`UMS_F_CRES]] * (1 << s[`UMS_F_MULT]) + CD + PD[s[`UMS_F_RATE]];
    if (t) k += CV[s[`UMS_F_TRES]] + TD;
    exp_clk = k * `UMS_CLK_KHZ / `UMS_OSC_KHZ;
  endfunction : exp_clk
  // Run one setup and judge six cycles
  task automatic run_cfg(input logic [15:0] s);
    logic [31:0] rd;
    int nt;
    wb(1'b1, `UMS_ADR_SETUP, {16'h0, s}, rd);
    wb(1'b0, `UMS_ADR_SETUP, 32'h0, rd);
    chk("setup", {16'h0, s}, rd);
    wait_pulse();
    wait_pulse();
    nt = 0;
    for (int i = 0; i < 6; i++) begin
      wait_pulse();
      nt += int'(temp);
      chk_near("spacing", exp_clk(s, temp), gap);
      chk("pdown", {31'h0, s[`UMS_F_RATE] != 2'h0}, {31'h0, pdown});
      chk("strobes", {28'h0, 1'b1, s[`UMS_B_CDENS], s[`UMS_B_TDENS], s[`UMS_B_ALARM]},
        {28'h0, last});
    end
    chk("temp count", 32'h1, nt);
    $display("test setup %h done", s);
  endtask : run_cfg
  // Main sequence
  initial begin
    logic [31:0] rd;
    int n;
    umsch_activity_t a;
    NRST = 1'b0;
    req = '0;
    ce = 1'b1;
    wsel = 4'hf;
    cycles = 0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(80));
    repeat (2) @(posedge CLK);
    chk("reset outs", 32'h0, {23'h0, act, refr, ack_o});
    NRST <= 1'b1;
    wb(1'b0, `UMS_ADR_SETUP, 32'h0, rd);
    chk("setup reset", 32'h1, rd);
    wb(1'b1, 4'h8, 32'hffff_ffff, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wait_pulse();
    chk("first temp", 32'h1, {31'h0, temp});
    $display("test reset done");
    run_cfg(16'h0001);
    run_cfg(16'h0fff);
    for (int i = 0; i < 4; i++) run_cfg(16'($urandom()) | 16'h0001);
    wb(1'b1, `UMS_ADR_SETUP, 32'h0000_0a00, rd);
    for (int k = 0; k < 5000 && act !== '0; k++) @(posedge CLK);
    chk("idle", 32'h0, {28'h0, act});
    repeat (2) @(posedge CLK);
    n = pulses;
    repeat (300) @(posedge CLK);
    chk("halted", n, pulses);
    wb(1'b0, `UMS_ADR_STATUS, 32'h0, rd);
    chk("phase", 32'h0, {29'h0, rd[`UMS_F_ST_PHASE]});
    chk("caps", {16'h0, 16'(pulses)}, {16'h0, rd[`UMS_F_ST_CAPS]});
    chk("tcnt", 32'(pulses % 6), {29'h0, rd[`UMS_F_ST_TCNT]});
    wsel = 4'h2;
    wb(1'b1, `UMS_ADR_SETUP, 32'h0000_05ff, rd);
    wsel = 4'hf;
    wb(1'b0, `UMS_ADR_SETUP, 32'h0, rd);
    chk("byte lanes", 32'h0000_0500, rd);
    wb(1'b1, `UMS_ADR_SETUP, 32'h0000_0a01, rd);
    wait_pulse();
    chk("reentry temp", 32'h1, {31'h0, temp});
    ce <= 1'b0;
    @(posedge CLK);
    a = act;
    n = pulses;
    repeat (100) @(posedge CLK);
    chk("frozen act", {28'h0, a}, {28'h0, act});
    chk("frozen pulses", n, pulses);
    ce <= 1'b1;
    wait_pulse();
    chk("second temp", 32'h0, {31'h0, temp});
    $display("test reentry done");
    test_done();
  end
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
endmodule : testbench

/* File: test/umsch_out_model.sv */
// Purpose: Output stage model fed by the scheduler refresh strobes
// Assumes: One clock, refresh strobes last one cycle
// Notes: Keeps the record of the last completed measurement cycle
`timescale 1ns/1ps
module umsch_out_model import umsch_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire umsch_refresh_t refresh,
  input wire umsch_activity_t activity,
  output int pulses_ff,
  output int gap_ff,
  output logic temp_ff,
  output logic pdown_ff,
  output umsch_refresh_t last_ff
);
  int cnt_ff; // Clocks since last refresh
  logic tseen_ff; // Temperature work seen
  logic pseen_ff; // Power-down seen
  // Record spacing and content at each register refresh
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulses_ff <= 0;
      gap_ff <= 0;
      temp_ff <= 1'b0;
      pdown_ff <= 1'b0;
      last_ff <= '0;
      cnt_ff <= 0;
      tseen_ff <= 1'b0;
      pseen_ff <= 1'b0;
    end else if (refresh.out_reg) begin
      pulses_ff <= pulses_ff + 1;
      gap_ff <= cnt_ff;
      temp_ff <= tseen_ff;
      pdown_ff <= pseen_ff;
      last_ff <= refresh;
      cnt_ff <= 1;
      tseen_ff <= 1'b0;
      pseen_ff <= activity.pwr_down;
    end else begin // Accumulate over the cycle
      cnt_ff <= cnt_ff + 1;
      tseen_ff <= tseen_ff | activity.temp_busy;
      pseen_ff <= pseen_ff | activity.pwr_down;
    end
  end
endmodule : umsch_out_model
